// file: hdl/sac_map.svh
// Named constants for the converter control block: timing and frame sizes.
// Assumes a 25 MHz system clock; included by bare name.
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH

// System clock period in ns
`define SAC_CLK_NS 40
// Conversion time bounds in ns
`define SAC_CONV_MIN_NS 500
`define SAC_CONV_MAX_NS 710
// Conversion length in cycles, least time rounded up
`define SAC_CONV_CYC ((`SAC_CONV_MIN_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
// Result width and index of its sign bit
`define SAC_RES_BITS 16
`define SAC_MSB 15
// Falling edges per frame without and with the busy bit
`define SAC_PLAIN_LEN 5'h10
`define SAC_BUSY_LEN 5'h11
// Level of the busy bit
`define SAC_BUSY_LVL 1'b0

`endif

// file: hdl/sac_pkg.sv
// Types shared by the converter control block.
// Assumes the constants header is available on the include path.
`default_nettype none

package sac_pkg;

    // Converter phase
    typedef enum logic {
        SAC_ACQ,
        SAC_CONV
    } sac_phase_t;

    // Result word as sent on the serial output
    typedef logic [15:0] sac_word_t;

    // Count of serial clock falling edges in a frame
    typedef logic [4:0] sac_edge_t;

endpackage

`default_nettype wire

// file: hdl/sac_sync.sv
// Two-flop synchroniser for the two control pins of the converter.
// Assumes asynchronous pin levels and a free-running clock.
`timescale 1ns/1ps
`default_nettype none

module sac_sync (
    input wire logic clock,
    input wire logic rstn,
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_sync
);

    logic [1:0] meta_ff;
    logic [1:0] nxt_meta;
    logic [1:0] sync_ff;
    logic [1:0] nxt_sync;

    // First stage feeds only the second stage
    always_comb begin
        nxt_meta = pin_in;
        nxt_sync = meta_ff;
    end

    // Pins idle high, so reset to high
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta_ff <= 2'h3;
            sync_ff <= 2'h3;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign pin_sync = sync_ff;

endmodule

`default_nettype wire

// file: hdl/sac_ctrl.sv
// Conversion timing, mode capture and serial read-out of the converter.
// Assumes an analog core that presents an offset-binary code at the end of
// conversion, and a host that only clocks sclk while a frame is open.
`timescale 1ns/1ps
`default_nettype none
`include "sac_map.svh"

// Summary of operation
// - A high data input at the start edge selects chip-select mode.
// - A low data input at the start edge, or one tied to start, selects daisy-chain mode.
// - Either mode may send a busy bit before the result to wake the host.
// - Chip-select mode works three-wire or four-wire, each with or without the busy bit.
// - Conversion is timed by the internal clock alone.
// - From the start edge the inputs are held off the sampling array until conversion ends.
// - After conversion the inputs reconnect, the core powers down and the result is readable.
// - The serial clock only shifts out read data and never drives conversion.
// - The host waits at least the longest conversion time before reading.
// - Results are sent as two's complement values.
// - The start edge tri-states the output, samples the input and starts conversion.
// - Without the busy bit the output releases after the 16th falling edge or on deselect.
// - With the busy bit a low bit appears at conversion end, then MSB first, release after 17.
module sac_ctrl (
    input wire logic clock,
    input wire logic rstn,
    input wire logic convert_start,
    input wire logic serial_data_in,
    input wire logic sclk,
    input wire logic [15:0] core_code,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    output logic input_connect,
    output logic core_power_en,
    output logic conv_busy
);

    localparam int ConvCyc = `SAC_CONV_CYC;

    // Bit of the result that goes out at a given edge count
    function automatic logic pick_bit(input sac_pkg::sac_word_t word,
                                      input sac_pkg::sac_edge_t cnt,
                                      input logic busy);
        logic [4:0] idx;
        idx = 5'(`SAC_MSB) + {4'h0, busy} - cnt;
        if (busy && cnt == 5'h00) begin
            pick_bit = `SAC_BUSY_LVL;
        end else begin
            pick_bit = word[idx[3:0]];
        end
    endfunction

    logic [1:0] pins_s;
    logic cvs_s;
    logic din_s;

    sac_sync u_sync (
        .clock(clock),
        .rstn(rstn),
        .pin_in({convert_start, serial_data_in}),
        .pin_sync(pins_s)
    );

    assign cvs_s = pins_s[1];
    assign din_s = pins_s[0];

    sac_pkg::sac_phase_t phase_ff, nxt_phase;
    logic [4:0] cnt_ff, nxt_cnt;
    logic cvs_d_ff, nxt_cvs_d;
    logic din_d_ff, nxt_din_d;
    logic mode_cs_ff, nxt_mode_cs;
    logic busy_ind_ff, nxt_busy_ind;
    logic rdy_ff, nxt_rdy;
    logic frame_ff, nxt_frame;
    sac_pkg::sac_word_t result_ff, nxt_result;
    logic start;
    logic sel_low;
    logic conv_end;

    // Host select: three-wire uses start low, four-wire uses data-in low
    assign sel_low = mode_cs_ff ? !(cvs_s && din_s) : !cvs_s;
    assign start = cvs_s && !cvs_d_ff;
    assign conv_end = (phase_ff == sac_pkg::SAC_CONV) &&
                      (cnt_ff == 5'(ConvCyc - 1));

    // Conversion sequencer on the system clock only
    always_comb begin
        nxt_phase = phase_ff;
        nxt_cnt = cnt_ff;
        nxt_cvs_d = cvs_s;
        nxt_din_d = din_s;
        nxt_mode_cs = mode_cs_ff;
        nxt_busy_ind = busy_ind_ff;
        nxt_rdy = rdy_ff;
        nxt_result = result_ff;
        nxt_frame = rdy_ff && sel_low && !start;
        unique case (phase_ff)
            sac_pkg::SAC_ACQ: begin
                // Start edges during conversion are ignored
                if (start) begin
                    nxt_phase = sac_pkg::SAC_CONV;
                    nxt_cnt = 5'h00;
                    // Pre-edge level: data-in tied to start reads low
                    nxt_mode_cs = din_d_ff;
                    nxt_rdy = 1'b0;
                end
            end
            sac_pkg::SAC_CONV: begin
                nxt_cnt = cnt_ff + 5'h01;
                if (conv_end) begin
                    nxt_phase = sac_pkg::SAC_ACQ;
                    nxt_result = {~core_code[`SAC_MSB],
                                  core_code[`SAC_MSB-1:0]};
                    nxt_rdy = 1'b1;
                    // Select low at the end asks for a busy bit
                    nxt_busy_ind = sel_low;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            phase_ff <= sac_pkg::SAC_ACQ;
            cnt_ff <= 5'h00;
            cvs_d_ff <= 1'b1;
            din_d_ff <= 1'b1;
            mode_cs_ff <= 1'b1;
            busy_ind_ff <= 1'b0;
            rdy_ff <= 1'b0;
            frame_ff <= 1'b0;
            result_ff <= 16'h0000;
        end else begin
            phase_ff <= nxt_phase;
            cnt_ff <= nxt_cnt;
            cvs_d_ff <= nxt_cvs_d;
            din_d_ff <= nxt_din_d;
            mode_cs_ff <= nxt_mode_cs;
            busy_ind_ff <= nxt_busy_ind;
            rdy_ff <= nxt_rdy;
            frame_ff <= nxt_frame;
            result_ff <= nxt_result;
        end
    end

    // Analog core controls follow the phase
    assign input_connect = (phase_ff == sac_pkg::SAC_ACQ);
    assign core_power_en = (phase_ff == sac_pkg::SAC_CONV);
    assign conv_busy = (phase_ff == sac_pkg::SAC_CONV);

    // Link side: frame_ff low holds the edge counter cleared, since sclk
    // may stand still between frames and cannot clear it by itself
    sac_pkg::sac_edge_t lcnt_ff, nxt_lcnt;
    logic [4:0] frame_len;
    logic link_done;

    // Busy choice is frozen before the frame opens, so it is stable here
    assign frame_len = busy_ind_ff ? `SAC_BUSY_LEN : `SAC_PLAIN_LEN;
    assign link_done = (lcnt_ff == frame_len);

    always_comb begin
        nxt_lcnt = lcnt_ff;
        if (!link_done) begin
            nxt_lcnt = lcnt_ff + 5'h01;
        end
    end

    always_ff @(negedge sclk or negedge frame_ff) begin
        if (!frame_ff) begin
            lcnt_ff <= 5'h00;
        end else begin
            lcnt_ff <= nxt_lcnt;
        end
    end

    // Output only in an open frame and before the last edge
    assign serial_data_out_oe = frame_ff && !link_done;
    assign serial_data_out = pick_bit(result_ff, lcnt_ff, busy_ind_ff);

    property p_cs_mode;
        @(posedge clock) disable iff (!rstn)
        (phase_ff == sac_pkg::SAC_ACQ) && start && din_d_ff |=> mode_cs_ff;
    endproperty
    a_cs_mode: assert property (p_cs_mode)
        else $error("start with data-in high did not pick cs mode");

    property p_daisy_mode;
        @(posedge clock) disable iff (!rstn)
        (phase_ff == sac_pkg::SAC_ACQ) && start && !din_d_ff |=> !mode_cs_ff;
    endproperty
    a_daisy_mode: assert property (p_daisy_mode)
        else $error("start with data-in low did not pick daisy mode");

    property p_mode_hold;
        @(posedge clock) disable iff (!rstn)
        !start |=> $stable(mode_cs_ff);
    endproperty
    a_mode_hold: assert property (p_mode_hold)
        else $error("mode changed without a start edge");

    property p_conv_len;
        @(posedge clock) disable iff (!rstn)
        (phase_ff == sac_pkg::SAC_ACQ) && start |=>
            conv_busy ##ConvCyc !conv_busy;
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("conversion length differs from internal count");

    property p_inputs_off;
        @(posedge clock) disable iff (!rstn)
        (phase_ff == sac_pkg::SAC_ACQ) && start |=>
            (!input_connect && core_power_en) [*8];
    endproperty
    a_inputs_off: assert property (p_inputs_off)
        else $error("inputs connected during conversion");

    property p_conv_done;
        @(posedge clock) disable iff (!rstn)
        conv_end |=> input_connect && !core_power_en && rdy_ff;
    endproperty
    a_conv_done: assert property (p_conv_done)
        else $error("acquisition not entered after conversion");

    property p_twos;
        @(posedge clock) disable iff (!rstn)
        conv_end |=> result_ff == {~$past(core_code[`SAC_MSB]),
                                   $past(core_code[`SAC_MSB-1:0])};
    endproperty
    a_twos: assert property (p_twos)
        else $error("result not in two's complement");

    property p_start_tristate;
        @(posedge clock) disable iff (!rstn)
        (phase_ff == sac_pkg::SAC_ACQ) && start |=>
            !serial_data_out_oe [*2];
    endproperty
    a_start_tristate: assert property (p_start_tristate)
        else $error("output driven after start edge");

    property p_busy_bit;
        @(posedge clock) disable iff (!rstn)
        conv_end && sel_low ##1 sel_low && !start |=>
            serial_data_out_oe && serial_data_out == `SAC_BUSY_LVL;
    endproperty
    a_busy_bit: assert property (p_busy_bit)
        else $error("busy bit missing after conversion");

    property p_release;
        @(posedge clock) disable iff (!rstn)
        $fell(serial_data_out_oe) |-> !frame_ff || link_done;
    endproperty
    a_release: assert property (p_release)
        else $error("output still driven after last falling edge");

endmodule

`default_nettype wire

// file: verif/sac_host_model.sv
// Host partner: start and select pins, serial clock, frame capture.
// Assumes calls come from the bench right after a system clock edge.
`timescale 1ns/1ps
`default_nettype none

module sac_host_model (
    input wire logic clock,
    input wire logic serial_data_out,
    input wire logic serial_data_out_oe,
    output logic convert_start,
    output logic serial_data_in,
    output logic sclk
);
    logic four_wire = 1'b0;
    // Board pull-up, so a released output never shows its last bit
    wire logic dout_line = serial_data_out_oe ? serial_data_out : 1'b1;

    initial begin
        convert_start = 1'b0;
        serial_data_in = 1'b1;
        sclk = 1'b0;
    end

    // Data pin level at the start edge picks the mode
    task automatic start_conv(input logic cs, input logic wire4);
        @(posedge clock);
        four_wire = wire4;
        convert_start <= 1'b0;
        serial_data_in <= cs;
        repeat (3) @(posedge clock);
        convert_start <= 1'b1;
        // Daisy start raises data-in with start, as if the pins were tied
        if (!cs) serial_data_in <= 1'b1;
        @(posedge clock);
        if (!cs) serial_data_in <= 1'b0;
    endtask

    // Active-low select: data pin in four-wire, start pin otherwise
    task automatic select(input logic lvl);
        if (four_wire) begin
            serial_data_in <= lvl;
        end else begin
            convert_start <= lvl;
        end
    endtask

    // Serial clock runs only inside a frame, so it cannot time conversion
    task automatic shift(input int nf, output logic [16:0] got);
        got = 17'h00000;
        #17;
        for (int i = 0; i < nf; i++) begin
            #62.5 sclk = 1'b1;
            got[i] = dout_line;
            #62.5 sclk = 1'b0;
        end
    endtask
endmodule

`default_nettype wire

// file: verif/tb_sar_adc_conversion_and_mode_select.sv
// Bench for the converter control: all interface options, corner codes.
// Assumes the design sources and the host partner are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_sar_adc_conversion_and_mode_select;
    logic clock, rstn, convert_start, serial_data_in, sclk;
    logic serial_data_out, serial_data_out_oe, input_connect;
    logic core_power_en, conv_busy;
    logic [15:0] core_code, code, want;
    logic [15:0] corners [4] = '{16'h0000, 16'hFFFF, 16'h8000, 16'h7FFF};
    logic [16:0] got;
    logic exp_q[$];
    int errors, checks_done, cycles, seed, nbusy, nrd;

    sac_ctrl i_sac_ctrl (.clock, .rstn, .convert_start, .serial_data_in,
        .sclk, .core_code, .serial_data_out, .serial_data_out_oe,
        .input_connect, .core_power_en, .conv_busy);
    sac_host_model i_sac_host_model (.clock, .serial_data_out,
        .serial_data_out_oe, .convert_start, .serial_data_in, .sclk);

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // Hang guard, far above the planned run of about 1060 cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            summarize();
        end
    end

    task automatic check(input string name, input logic [15:0] seen,
        input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        if (errors == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // One conversion and read; m 0 three-wire, 1 four-wire, 2 daisy
    task automatic run(input logic [15:0] c, input int m, input logic bsy,
        input int cut);
        @(posedge clock);
        core_code <= c;
        want = c ^ 16'h8000;
        nrd = (cut != 0) ? cut : (bsy ? 17 : 16);
        exp_q = {};
        if (bsy) exp_q.push_back(1'b0);
        for (int i = 15; i >= 0; i--) exp_q.push_back(want[i]);
        i_sac_host_model.start_conv(m != 2, m == 1);
        nbusy = 0;
        for (int k = 0; k < 40; k++) begin
            @(posedge clock);
            nbusy += (conv_busy === 1'b1);
            // Early select asks for the busy bit, late one after 710 ns
            if (k == 6 && bsy) i_sac_host_model.select(1'b0);
            if (k == 21 && !bsy) i_sac_host_model.select(1'b0);
            if (k == 10) check("conv", {input_connect, core_power_en,
                serial_data_out_oe}, 3'b010);
            if (k == 20) check("early", serial_data_out_oe, bsy);
        end
        check("length", nbusy, 13);
        check("acq", {input_connect, core_power_en}, 2'b10);
        check("open", serial_data_out_oe, 1'b1);
        i_sac_host_model.shift(nrd, got);
        for (int i = 0; i < nrd; i++) check("bit", got[i], exp_q[i]);
        repeat (3) @(posedge clock);
        check("count", serial_data_out_oe, nrd < exp_q.size());
        i_sac_host_model.select(1'b1);
        repeat (6) @(posedge clock);
        check("deselect", serial_data_out_oe, 1'b0);
        // In three-wire and daisy the deselect also starts a conversion
        repeat (30) @(posedge clock);
    endtask

    initial begin
        rstn = 1'b0;
        core_code = 16'h0000;
        seed = 32'h08B0;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        repeat (2) @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            code = (i < 4) ? corners[i] : 16'($random(seed));
            run(code, i % 3, i >= 3 && i < 6, (i >= 6) ? i + 3 : 0);
        end
        summarize();
    end
endmodule

`default_nettype wire
